// ### core/dds_core.sv
// phase accumulator, phase offset adder and sine path feeding the dac word
// assumes tuning words and control bits come from logic on the same clock
//
// Behaviour
// - 28-bit accumulator adds selected word, wraps
// - output frequency is word times clock over 2^28
// - two frequency words, chosen by select bit
// - select switch never clears the accumulator
// - offset added to accumulator top bits
// - two 12-bit offsets, step one 4096th turn
// - phase truncated to 12 bits for address
// - table gives 10-bit amplitude to dac
// - mode bit bypasses the sine table
// - reset bit holds accumulator, output at midscale
// - first sample eight cycles after reset release
// - new word reaches output in 7-8 cycles
`timescale 1ns/1ps
`default_nettype none
module dds_core (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // frequency tuning
    input wire logic [27:0] freq_word_a,
    input wire logic [27:0] freq_word_b,
    input wire logic freq_word_choice,
    // phase offsets
    input wire logic [11:0] phase_word_a,
    input wire logic [11:0] phase_word_b,
    input wire logic phase_choice,
    // control
    input wire logic hold_reset,
    input wire logic mode_bypass,
    // dac side
    output logic [9:0] dac_word,
    output logic sample_valid
);
    // ==========================================================
    // stage 1: capture of tuning and control
    logic [27:0] fa_q;
    logic [27:0] fb_q;
    logic fsel_q;
    logic [11:0] pa_q;
    logic [11:0] pb_q;
    logic psel_q;
    logic byp_q;
    logic run_q;
    logic [27:0] step;
    logic [11:0] offset;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fa_q <= dds_pkg::ACC_RESET;
            fb_q <= dds_pkg::ACC_RESET;
            fsel_q <= 1'b0;
        end else begin
            fa_q <= freq_word_a;
            fb_q <= freq_word_b;
            fsel_q <= freq_word_choice;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pa_q <= 12'h000;
            pb_q <= 12'h000;
            psel_q <= 1'b0;
        end else begin
            pa_q <= phase_word_a;
            pb_q <= phase_word_b;
            psel_q <= phase_choice;
        end
    end

    // the held words are not touched by the reset bit, only the accumulator
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_q <= 1'b0;
            byp_q <= 1'b0;
        end else begin
            run_q <= !hold_reset;
            byp_q <= mode_bypass;
        end
    end

    assign step = fsel_q ? fb_q : fa_q;
    assign offset = psel_q ? pb_q : pa_q;

    // ==========================================================
    // stage 2: accumulator
    // natural 28-bit wrap gives f = word * fclk / 2^28
    logic [27:0] accum;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accum <= dds_pkg::ACC_RESET;
        end else if (!run_q) begin
            accum <= dds_pkg::ACC_RESET;
        end else begin
            accum <= 28'(accum + step);
        end
    end

    // ==========================================================
    // stage 3: offset add and truncation
    logic [11:0] phase_addr;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_addr <= 12'h000;
        end else begin
            phase_addr <= 12'(accum[27:dds_pkg::TRUNC_LSB] + offset);
        end
    end

    // ==========================================================
    // stages 4 to 6: sine table, bypass word kept in step with it
    logic [9:0] rom_word;
    logic [9:0] byp_d [dds_pkg::ROM_LAT];
    logic [dds_pkg::MODE_DEPTH-1:0] mode_pipe;

    dds_sine_rom u_rom (
        .clk(clk),
        .rstn(rstn),
        .addr(phase_addr),
        .word(rom_word)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < dds_pkg::ROM_LAT; i++) begin
                byp_d[i] <= dds_pkg::MIDSCALE;
            end
        end else begin
            byp_d[0] <= phase_addr[11:2];
            for (int i = 1; i < dds_pkg::ROM_LAT; i++) begin
                byp_d[i] <= byp_d[i-1];
            end
        end
    end

    // mode travels with the sample it was applied to
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_pipe <= '0;
        end else begin
            mode_pipe <= {mode_pipe[dds_pkg::MODE_DEPTH-2:0], byp_q};
        end
    end

    // ==========================================================
    // stage 7: mode select; stage 8: dac register
    logic [9:0] shaped;
    logic [dds_pkg::VLD_DEPTH-1:0] vld;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shaped <= dds_pkg::MIDSCALE;
        end else begin
            shaped <= mode_pipe[dds_pkg::MODE_DEPTH-1] ? byp_d[dds_pkg::ROM_LAT-1] : rom_word;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vld <= '0;
        end else begin
            vld <= {vld[dds_pkg::VLD_DEPTH-2:0], run_q};
        end
    end

    // samples still in flight from a held accumulator are masked to midscale
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_word <= dds_pkg::MIDSCALE;
            sample_valid <= 1'b0;
        end else begin
            dac_word <= vld[dds_pkg::VLD_DEPTH-1] ? shaped : dds_pkg::MIDSCALE;
            sample_valid <= vld[dds_pkg::VLD_DEPTH-1];
        end
    end

    // ==========================================================
    // checks
    property p_accum_step;
        @(posedge clk) disable iff (!rstn)
        (run_q && $past(run_q)) |-> (accum == 28'($past(accum) + $past(step)));
    endproperty
    a_accum_step: assert property (p_accum_step) else $error("accumulator step wrong");

    property p_select_continuous;
        @(posedge clk) disable iff (!rstn)
        (run_q && $past(run_q) && $changed(fsel_q)) |=>
            (accum == 28'($past(accum) + ($past(fsel_q) ? $past(fb_q) : $past(fa_q))));
    endproperty
    a_select_continuous: assert property (p_select_continuous)
        else $error("select switch disturbed phase");

    property p_offset_add;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> (phase_addr == 12'($past(accum[27:16]) + $past(offset)));
    endproperty
    a_offset_add: assert property (p_offset_add) else $error("offset add wrong");

    property p_hold_zero;
        @(posedge clk) disable iff (!rstn)
        !run_q |=> (accum == 28'h000_0000);
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("accumulator not held");

    property p_hold_mid;
        @(posedge clk) disable iff (!rstn)
        !run_q |-> ##7 (!sample_valid && dac_word == 10'h200);
    endproperty
    a_hold_mid: assert property (p_hold_mid) else $error("output not midscale in reset");

    property p_start_latency;
        @(posedge clk) disable iff (!rstn)
        (hold_reset ##1 !hold_reset [*8]) |-> (!sample_valid ##1 sample_valid);
    endproperty
    a_start_latency: assert property (p_start_latency)
        else $error("first sample not eight cycles after release");

    // vld[4] now is the bit that masks this word at the dac register two edges later
    property p_bypass_path;
        @(posedge clk) disable iff (!rstn)
        (mode_pipe[4] && vld[4]) |-> ##2 (dac_word == $past(phase_addr[11:2], 5));
    endproperty
    a_bypass_path: assert property (p_bypass_path) else $error("bypass word wrong");

    property p_sine_path;
        @(posedge clk) disable iff (!rstn)
        (!mode_pipe[4] && vld[4]) |-> ##2 (dac_word == $past(rom_word, 2));
    endproperty
    a_sine_path: assert property (p_sine_path) else $error("sine word not forwarded");

    c_release: cover property (@(posedge clk) disable iff (!rstn) $rose(sample_valid));
    c_switch: cover property (@(posedge clk) disable iff (!rstn) run_q && $changed(fsel_q));
    c_bypass: cover property (@(posedge clk) disable iff (!rstn) sample_valid && mode_pipe[4]);
    c_wrap: cover property (@(posedge clk) disable iff (!rstn) run_q && (accum < $past(accum)));
endmodule
`default_nettype wire

// ### core/dds_sine_rom.sv
// sine table: 12-bit phase address in, 10-bit offset-binary amplitude out
// assumes it is fed from a register on the same clock; latency is three edges
`timescale 1ns/1ps
`default_nettype none
module dds_sine_rom (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // phase in
    input wire logic [11:0] addr,
    // amplitude out
    output logic [9:0] word
);
    // ==========================================================
    // quarter-wave knots with linear interpolation
    // trades a full 4096 entry table for 17 knots and one small multiply
    function automatic logic [8:0] sine_knot(input logic [4:0] k);
        logic [8:0] v;
        v = 9'h000;
        unique case (k)
            5'd0: v = 9'h000;
            5'd1: v = 9'h032;
            5'd2: v = 9'h064;
            5'd3: v = 9'h094;
            5'd4: v = 9'h0c4;
            5'd5: v = 9'h0f1;
            5'd6: v = 9'h11c;
            5'd7: v = 9'h144;
            5'd8: v = 9'h169;
            5'd9: v = 9'h18b;
            5'd10: v = 9'h1a9;
            5'd11: v = 9'h1c3;
            5'd12: v = 9'h1d8;
            5'd13: v = 9'h1e9;
            5'd14: v = 9'h1f5;
            5'd15: v = 9'h1fd;
            default: v = 9'h1ff;
        endcase
        return v;
    endfunction

    logic [9:0] quarter;
    logic [4:0] seg;
    logic [8:0] base_a;
    logic [8:0] diff_a;
    logic [5:0] frac_a;
    logic neg_a;
    logic [8:0] mag_b;
    logic neg_b;
    logic [14:0] prod;

    // odd quadrants run backwards through the quarter wave
    assign quarter = addr[10] ? ~addr[9:0] : addr[9:0];
    assign seg = {1'b0, quarter[9:6]};
    assign prod = 15'(diff_a * frac_a);

    // ==========================================================
    // stage a: knot fetch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            base_a <= 9'h000;
            diff_a <= 9'h000;
            frac_a <= 6'h00;
            neg_a <= 1'b0;
        end else begin
            base_a <= sine_knot(seg);
            diff_a <= 9'(sine_knot(5'(seg + 5'd1)) - sine_knot(seg));
            frac_a <= quarter[5:0];
            neg_a <= addr[11];
        end
    end

    // stage b: interpolate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mag_b <= 9'h000;
            neg_b <= 1'b0;
        end else begin
            mag_b <= 9'(base_a + 9'(prod >> dds_pkg::FRAC_W));
            neg_b <= neg_a;
        end
    end

    // stage c: fold sign around midscale
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word <= dds_pkg::MIDSCALE;
        end else begin
            word <= neg_b ? 10'(dds_pkg::MIDSCALE - mag_b) : 10'(dds_pkg::MIDSCALE + mag_b);
        end
    end

    // ==========================================================
    // checks
    property p_rom_zero;
        @(posedge clk) disable iff (!rstn)
        (addr == 12'h000) |-> ##3 (word == 10'h200);
    endproperty
    a_rom_zero: assert property (p_rom_zero) else $error("sine zero not midscale");

    property p_rom_peak;
        @(posedge clk) disable iff (!rstn)
        (addr == 12'h400) |-> ##3 (word == 10'h3fe);
    endproperty
    a_rom_peak: assert property (p_rom_peak) else $error("sine peak wrong");

    property p_rom_trough;
        @(posedge clk) disable iff (!rstn)
        (addr == 12'hc00) |-> ##3 (word == 10'h002);
    endproperty
    a_rom_trough: assert property (p_rom_trough) else $error("sine trough wrong");
endmodule
`default_nettype wire

// ### dv/dds_dac_model.sv
// behavioural model of the 10-bit dac that sits after the core
// assumes words arrive registered on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module dds_dac_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // dac input
    input wire logic [9:0] dac_word,
    input wire logic sample_valid,
    // analog view and measured period
    output var real vout,
    output var int period
);
    // ==========================================================
    // conversion
    logic [9:0] last;
    int since;
    // 0.6 V peak to peak across the full code range
    assign vout = 0.6 * real'(dac_word) / 1023.0;
    // ==========================================================
    // period between upward midscale crossings, in samples
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last <= dds_pkg::MIDSCALE;
            since <= 0;
            period <= 0;
        end else if (sample_valid === 1'b1) begin
            since <= since + 1;
            if (last < dds_pkg::MIDSCALE && dac_word >= dds_pkg::MIDSCALE) begin
                period <= since + 1;
                since <= 0;
            end
            last <= dac_word;
        end
    end
endmodule
`default_nettype wire

// ### dv/test_dds_core.sv
// self-checking bench for the phase accumulator and sine core
// assumes dds_pkg and the dac model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_dds_core;
    // ==========================================================
    // signals
    logic clk;
    logic rstn;
    logic [27:0] freq_word_a;
    logic [27:0] freq_word_b;
    logic freq_word_choice;
    logic [11:0] phase_word_a;
    logic [11:0] phase_word_b;
    logic phase_choice;
    logic hold_reset;
    logic mode_bypass;
    logic [9:0] dac_word;
    logic sample_valid;
    real vout;
    int period;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    integer seed = 83;
    logic [13:0] notes[$];
    logic [13:0] note;
    dds_core uut (
        .clk(clk), .rstn(rstn), .freq_word_a(freq_word_a), .freq_word_b(freq_word_b),
        .freq_word_choice(freq_word_choice), .phase_word_a(phase_word_a),
        .phase_word_b(phase_word_b), .phase_choice(phase_choice), .hold_reset(hold_reset),
        .mode_bypass(mode_bypass), .dac_word(dac_word), .sample_valid(sample_valid)
    );
    dds_dac_model dac (
        .clk(clk), .rstn(rstn), .dac_word(dac_word), .sample_valid(sample_valid),
        .vout(vout), .period(period)
    );
    // ==========================================================
    // reporting
    task automatic fail(input string msg);
        miscompares++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("word %h, want %h", got, exp));
    endtask
    task automatic cmp_near(input logic [9:0] got, input logic [11:0] a);
        real e;
        e = 512.0 + 510.0 * $sin(6.283185307 * real'(a) / 4096.0);
        num_checks++;
        if ((^got === 1'bx) || real'(got) - e > 3.0 || e - real'(got) > 3.0)
            fail($sformatf("sine %h at phase %h", got, a));
    endtask
    task automatic cmp_int(input int got, input int exp);
        num_checks++;
        if (got != exp) fail($sformatf("count %0d, want %0d", got, exp));
    endtask
    task automatic end_sim;
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // reference pipeline: freq and mode sampled one edge ahead of phase
    logic [27:0] m_f;
    logic m_h;
    logic [27:0] m_acc;
    logic m_va;
    logic [11:0] m_p;
    logic m_m0;
    logic m_md;
    logic [13:0] m_st [5];
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            m_f <= '0;
            m_h <= 1'b1;
            m_acc <= '0;
            m_va <= 1'b0;
            m_p <= '0;
            m_m0 <= 1'b0;
            m_md <= 1'b0;
            for (int i = 0; i < 5; i++) m_st[i] <= '0;
            notes.delete();
        end else begin
            m_f <= freq_word_choice ? freq_word_b : freq_word_a;
            m_h <= hold_reset;
            m_acc <= m_h ? 28'h000_0000 : m_acc + m_f;
            m_va <= !m_h;
            m_p <= phase_choice ? phase_word_b : phase_word_a;
            m_m0 <= mode_bypass;
            m_md <= m_m0;
            m_st[0] <= {m_va, m_md, m_acc[27:16] + m_p};
            for (int i = 1; i < 5; i++) m_st[i] <= m_st[i-1];
            if (m_st[4][13]) notes.push_back(m_st[4]);
        end
    end
    // ==========================================================
    // monitor: settled outputs at the falling edge
    always @(negedge clk) begin
        if (rstn === 1'b1 && sample_valid === 1'b1) begin
            if (notes.size() == 0) begin
                fail("sample with nothing expected");
            end else begin
                note = notes.pop_front();
                if (note[12]) cmp_word(dac_word, note[11:2]);
                else cmp_near(dac_word, note[11:0]);
                if (!note[12] && note[10:0] == 11'h400)
                    cmp_word(dac_word, note[11] ? 10'h002 : 10'h3fe);
                if (!note[12] && note[10:0] == 11'h000)
                    cmp_word(dac_word, dds_pkg::MIDSCALE);
            end
        end else if (rstn === 1'b1) begin
            cmp_word(dac_word, dds_pkg::MIDSCALE);
            cmp_int(notes.size(), 0);
            notes.delete();
        end
    end
    // ==========================================================
    // clock and timeout
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail("timeout");
            end_sim();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        logic [31:0] r;
        rstn = 1'b0;
        {freq_word_a, freq_word_b, freq_word_choice} = '0;
        {phase_word_a, phase_word_b, phase_choice} = '0;
        hold_reset = 1'b1;
        mode_bypass = 1'b1;
        step(4);
        rstn = 1'b1;
        // parked: words change but output must stay at midscale
        freq_word_a = 28'h123_4567;
        phase_word_a = 12'h321;
        step(12);
        hold_reset = 1'b0;
        step(40);
        // random traffic with occasional hold pulses, wraps and mode flips
        for (int i = 0; i < 1200; i++) begin
            r = $random(seed);
            if (r[1:0] == 2'h0) freq_word_a = 28'($random(seed));
            if (r[3:2] == 2'h0) freq_word_b = 28'($random(seed));
            if (r[5:4] == 2'h0) freq_word_choice = ~freq_word_choice;
            if (r[8:6] == 3'h0) phase_word_a = 12'($random(seed));
            if (r[11:9] == 3'h0) phase_word_b = 12'($random(seed));
            if (r[13:12] == 2'h0) phase_choice = ~phase_choice;
            if (r[18:14] == 5'h00) mode_bypass = ~mode_bypass;
            hold_reset = (r[24:19] == 6'h00);
            step(1);
        end
        // sine period: 2^28 / 2^22 = 64 samples, then 2^23 gives 32
        {hold_reset, mode_bypass, freq_word_choice, phase_choice} = 4'b1000;
        {freq_word_a, freq_word_b} = {28'h040_0000, 28'h080_0000};
        {phase_word_a, phase_word_b} = 24'h000_400;
        step(4);
        hold_reset = 1'b0;
        step(300);
        cmp_int(period, 64);
        freq_word_choice = 1'b1;
        step(200);
        cmp_int(period, 32);
        // second reset in mid-run, hold already low
        rstn = 1'b0;
        step(2);
        rstn = 1'b1;
        step(100);
        end_sim();
    end
endmodule
`default_nettype wire

// ### pkg/dds_pkg.sv
// constants shared by the phase accumulator core and its sine table
// assumes a single clock domain; all widths fixed
package dds_pkg;
    // ==========================================================
    // widths
    localparam int ACC_W = 28;
    localparam int PH_W = 12;
    localparam int DAC_W = 10;
    localparam int MAG_W = 9;
    localparam int SEG_W = 4;
    localparam int FRAC_W = 6;
    localparam int TRUNC_LSB = ACC_W - PH_W;
    // ==========================================================
    // values
    localparam logic [DAC_W-1:0] MIDSCALE = 10'h200;
    localparam logic [ACC_W-1:0] ACC_RESET = 28'h000_0000;
    // ==========================================================
    // timing counts in clock cycles
    localparam int START_LAT = 8;
    localparam int ROM_LAT = 3;
    localparam int VLD_DEPTH = START_LAT - 2;
    localparam int MODE_DEPTH = 5;
endpackage
